// file: dv/pcsiu_monitor.sv
`timescale 1ns/1ps
module pcsiu_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// decoder and register file side
	input wire logic instr_valid,
	input wire pcsiu_pkg::pcsiu_instr_t instr,
	input wire logic [pcsiu_pkg::DATA_W-1:0] mem_rdata,
	// block outputs
	input wire logic [pcsiu_pkg::PC_W-1:0] program_counter_q,
	input wire logic [pcsiu_pkg::PC_W-1:0] exec_pc_q,
	input wire logic discard_q,
	input wire logic page_select_bit_lo_q,
	input wire logic page_select_bit_hi_q,
	input wire logic w_load_q,
	input wire logic [pcsiu_pkg::DATA_W-1:0] w_data_q,
	input wire pcsiu_pkg::pcsiu_mem_t mem_q,
	input wire logic rd_valid_q,
	input wire logic [pcsiu_pkg::DATA_W-1:0] rd_data_q
);
	// ----------------------------------------------------------------
	// instruction taken at this edge
	// ----------------------------------------------------------------
	logic take;
	assign take = instr_valid && !discard_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	seq_step_a: assert property (discard_q || take && instr.op == pcsiu_pkg::PCSIU_OP_SEQ && !instr.file_wr
		|=> program_counter_q == $past(program_counter_q) + pcsiu_pkg::PC_ONE) else $error("counter did not step");
	goto_load_a: assert property (take && instr.op == pcsiu_pkg::PCSIU_OP_GOTO
		|=> program_counter_q == $past(instr.target) && discard_q) else $error("jump load wrong");
	call_load_a: assert property (take && instr.op == pcsiu_pkg::PCSIU_OP_CALL
		|=> program_counter_q == {1'h0, $past(instr.target[7:0])} && discard_q) else $error("call load wrong");
	discard_once_a: assert property (discard_q |=> !discard_q) else $error("discard held");
	return_with_literal_lit_a: assert property (take && instr.op == pcsiu_pkg::PCSIU_OP_RETURN_WITH_LITERAL
		|=> w_load_q && w_data_q == $past(instr.literal) ##1 !w_load_q) else $error("literal load wrong");
	w_cause_a: assert property (w_load_q |-> $past(take && instr.op == pcsiu_pkg::PCSIU_OP_RETURN_WITH_LITERAL))
		else $error("stray literal load");
	reset_vec_a: assert property ($rose(rstn) |-> program_counter_q == pcsiu_pkg::PC_RESET
		&& !page_select_bit_lo_q && !page_select_bit_hi_q) else $error("reset state wrong");
	null_read_a: assert property (take && instr.file_rd && instr.file_addr == pcsiu_pkg::ADDR_INDIRECT
		##1 !mem_q.rd |=> rd_valid_q && rd_data_q == pcsiu_pkg::NULL_DATA) else $error("null read wrong");
	fwd_read_a: assert property (mem_q.rd && mem_q.addr != pcsiu_pkg::ADDR_POINTER
		|=> rd_valid_q && rd_data_q == $past(mem_rdata)) else $error("read data not forwarded");
	direct_wr_a: assert property (take && instr.file_wr && instr.file_addr != pcsiu_pkg::ADDR_INDIRECT
		|=> mem_q.wr && mem_q.addr == $past(instr.file_addr) && mem_q.wdata == $past(instr.file_wdata))
		else $error("direct write lost");
	exec_addr_a: assert property (exec_pc_q == $past(program_counter_q))
		else $error("executing address not tracked");
endmodule : pcsiu_monitor

// file: dv/pcsiu_regfile_model.sv
`timescale 1ns/1ps
module pcsiu_regfile_model (
	// clock
	input wire logic ref_clk,
	// access from the block
	input wire pcsiu_pkg::pcsiu_mem_t mem_q,
	// read answer
	output logic [pcsiu_pkg::DATA_W-1:0] mem_rdata
);
	logic [7:0] regs [32];
	logic [7:0] last;
	initial begin
		for (int i = 0; i < 32; i++) begin
			regs[i] = 8'(i) ^ 8'hA5;
		end
		regs[5] = 8'h10;
		regs[6] = 8'h0A;
		last = 8'h00;
	end
	// idle port shows the inverse of the last answer so a late sample cannot pass by luck
	always_comb begin
		mem_rdata = mem_q.rd ? regs[mem_q.addr] : ~last;
	end
	always @(posedge ref_clk) begin
		if (mem_q.rd) last <= regs[mem_q.addr];
		if (mem_q.wr) regs[mem_q.addr] <= mem_q.wdata;
	end
endmodule : pcsiu_regfile_model

// file: dv/pcsiu_top_tb.sv
`timescale 1ns/1ps
module pcsiu_top_tb;
	localparam pcsiu_pkg::pcsiu_op_t SEQ = pcsiu_pkg::PCSIU_OP_SEQ;
	localparam pcsiu_pkg::pcsiu_op_t JMP = pcsiu_pkg::PCSIU_OP_GOTO;
	localparam pcsiu_pkg::pcsiu_op_t CALL = pcsiu_pkg::PCSIU_OP_CALL;
	localparam pcsiu_pkg::pcsiu_op_t RET = pcsiu_pkg::PCSIU_OP_RETURN_WITH_LITERAL;
	localparam pcsiu_pkg::pcsiu_instr_t NOP = '{SEQ, 9'h000, 8'h00, 5'h00, 1'h0, 1'h0, 8'h00};
	logic ref_clk = 1'h0;
	logic rstn = 1'h0;
	logic instr_valid = 1'h0;
	pcsiu_pkg::pcsiu_instr_t instr = NOP;
	logic [7:0] mem_rdata;
	logic [8:0] program_counter_q;
	logic discard_q;
	logic page_select_bit_lo_q;
	logic page_select_bit_hi_q;
	logic w_load_q;
	logic [7:0] w_data_q;
	pcsiu_pkg::pcsiu_mem_t mem_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [8:0] exp_cnt;
	logic [11:0] stk [4];

	pcsiu_top i_pcsiu_top (.ref_clk, .rstn, .instr_valid, .instr, .mem_rdata, .program_counter_q,
		.exec_pc_q(), .discard_q, .page_select_bit_lo_q, .page_select_bit_hi_q, .w_load_q,
		.w_data_q, .mem_q, .rd_valid_q, .rd_data_q);
	pcsiu_regfile_model i_pcsiu_regfile_model (.ref_clk, .mem_q, .mem_rdata);

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			test_done();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset();
		@(posedge ref_clk);
		rstn <= 1'h0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'h1;
		instr_valid <= 1'h1;
		#1;
		exp_cnt = 9'h1FF;
		chk(program_counter_q, exp_cnt);
		chk({page_select_bit_hi_q, page_select_bit_lo_q}, 2'h0);
	endtask : do_reset

	// ----------------------------------------------------------------
	// one instruction, then a filler; counter and return stack tracked here
	// ----------------------------------------------------------------
	task automatic exe(input pcsiu_pkg::pcsiu_op_t op, input logic [8:0] tg, input logic [4:0] fa,
			input logic rd, input logic wr, input logic [7:0] d);
		logic br;
		br = (op != SEQ) || (wr && fa == pcsiu_pkg::ADDR_PC_LOW);
		exp_cnt = exp_cnt + 9'h001;
		@(posedge ref_clk);
		instr <= '{op, tg, d, fa, rd, wr, d};
		@(posedge ref_clk);
		instr <= NOP;
		#1;
		case (op)
			SEQ: exp_cnt = br ? {1'h0, d} : exp_cnt + 9'h001;
			JMP: exp_cnt = tg;
			CALL: begin
				for (int i = 3; i > 0; i--) stk[i] = stk[i-1];
				stk[0] = {3'h0, exp_cnt};
				exp_cnt = {1'h0, tg[7:0]};
			end
			default: begin
				exp_cnt = stk[0][8:0];
				for (int i = 0; i < 3; i++) stk[i] = stk[i+1];
				chk(w_data_q, d);
			end
		endcase
		chk(program_counter_q, exp_cnt);
		chk(discard_q, br);
		chk(w_load_q, op == RET);
	endtask : exe

	task automatic rd_chk(input logic [4:0] fa, input logic [7:0] exp);
		exe(SEQ, 9'h000, fa, 1'h1, 1'h0, 8'h00);
		@(posedge ref_clk);
		#1;
		exp_cnt = exp_cnt + 9'h001;
		chk(rd_valid_q, 1'h1);
		chk(rd_data_q, exp);
	endtask : rd_chk

	task automatic t_refuse();
		@(posedge ref_clk);
		instr <= '{JMP, 9'h0F0, 8'h00, 5'h00, 1'h0, 1'h0, 8'h00};
		@(posedge ref_clk);
		instr <= '{CALL, 9'h033, 8'h00, 5'h00, 1'h0, 1'h0, 8'h00};
		@(posedge ref_clk);
		instr <= NOP;
		#1;
		exp_cnt = 9'h0F1;
		chk(program_counter_q, exp_cnt);
	endtask : t_refuse

	task automatic t_flow();
		exe(SEQ, 9'h000, 5'h00, 1'h0, 1'h0, 8'h00);
		exe(JMP, 9'h1A5, 5'h00, 1'h0, 1'h0, 8'h00);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_PC_LOW, 1'h0, 1'h1, 8'h37);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_STATUS, 1'h0, 1'h1, 8'h40);
		chk({page_select_bit_hi_q, page_select_bit_lo_q}, 2'h2);
	endtask : t_flow

	task automatic t_stack();
		for (int i = 0; i < 6; i++) exe(CALL, 9'h1C0 + 9'(i * 17), 5'h00, 1'h0, 1'h0, 8'h00);
		t_refuse();
		for (int i = 0; i < 6; i++) exe(RET, 9'h000, 5'h00, 1'h0, 1'h0, 8'hC0 + 8'(i));
	endtask : t_stack

	task automatic t_reset_stack();
		exe(CALL, 9'h155, 5'h00, 1'h0, 1'h0, 8'h00);
		exe(CALL, 9'h0AA, 5'h00, 1'h0, 1'h0, 8'h00);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_STATUS, 1'h0, 1'h1, 8'h60);
		do_reset();
		exe(RET, 9'h000, 5'h00, 1'h0, 1'h0, 8'h5A);
		exe(RET, 9'h000, 5'h00, 1'h0, 1'h0, 8'hA5);
	endtask : t_reset_stack

	task automatic t_indirect();
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_POINTER, 1'h0, 1'h1, 8'h05);
		rd_chk(pcsiu_pkg::ADDR_INDIRECT, 8'h10);
		rd_chk(pcsiu_pkg::ADDR_POINTER, 8'h65);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_POINTER, 1'h0, 1'h1, 8'hFF);
		rd_chk(pcsiu_pkg::ADDR_POINTER, 8'h7F);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_POINTER, 1'h0, 1'h1, 8'h06);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_INDIRECT, 1'h0, 1'h1, 8'h3C);
		chk(mem_q.addr, 5'h06);
		rd_chk(5'h06, 8'h3C);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_POINTER, 1'h0, 1'h1, 8'h00);
		exe(SEQ, 9'h000, pcsiu_pkg::ADDR_INDIRECT, 1'h0, 1'h1, 8'h5A);
		chk(mem_q.wr, 1'h0);
		rd_chk(pcsiu_pkg::ADDR_INDIRECT, 8'h00);
	endtask : t_indirect

	task automatic test_done();
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	initial begin
		do_reset();
		t_flow();
		t_stack();
		t_reset_stack();
		t_indirect();
		test_done();
	end
endmodule : pcsiu_top_tb

bind pcsiu_top pcsiu_monitor i_pcsiu_monitor (.ref_clk, .rstn, .instr_valid, .instr, .mem_rdata,
	.program_counter_q, .exec_pc_q, .discard_q, .page_select_bit_lo_q, .page_select_bit_hi_q,
	.w_load_q, .w_data_q, .mem_q, .rd_valid_q, .rd_data_q);

// file: logic/pcsiu_indirect.sv
`timescale 1ns/1ps
module pcsiu_indirect (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// file access from the executing instruction
	input wire logic access_en,
	input wire logic [pcsiu_pkg::FADDR_W-1:0] file_addr,
	input wire logic file_rd,
	input wire logic file_wr,
	input wire logic [pcsiu_pkg::DATA_W-1:0] file_wdata,
	// resolved access, same cycle
	output logic [pcsiu_pkg::FADDR_W-1:0] eff_addr,
	output logic eff_wr,
	// registered access toward the register file
	output pcsiu_pkg::pcsiu_mem_t mem_q,
	output logic null_rd_q,
	output logic [pcsiu_pkg::DATA_W-1:0] ptr_view_q
);

	// ----------------------------------------------------------------
	// address resolution
	// ----------------------------------------------------------------
	logic [pcsiu_pkg::PTR_W-1:0] ptr_q;
	logic is_indirect;
	logic null_target;

	always_comb begin
		is_indirect = (file_addr == pcsiu_pkg::ADDR_INDIRECT);
		eff_addr = is_indirect ? ptr_q : file_addr;
		// pointer at zero turns the access into a null one
		null_target = (eff_addr == pcsiu_pkg::ADDR_INDIRECT);
		eff_wr = access_en && file_wr && !null_target;
	end

	// ----------------------------------------------------------------
	// pointer register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ptr_q <= pcsiu_pkg::PTR_RESET;
		end else if (eff_wr && eff_addr == pcsiu_pkg::ADDR_POINTER) begin
			ptr_q <= file_wdata[pcsiu_pkg::PTR_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ptr_view_q <= {pcsiu_pkg::PTR_UPPER_VIEW, pcsiu_pkg::PTR_RESET};
		end else begin
			ptr_view_q <= {pcsiu_pkg::PTR_UPPER_VIEW, ptr_q};
		end
	end

	// ----------------------------------------------------------------
	// registered access
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mem_q <= '0;
			null_rd_q <= 1'b0;
		end else begin
			mem_q.addr <= eff_addr;
			mem_q.rd <= access_en && file_rd && !null_target;
			mem_q.wr <= eff_wr;
			mem_q.wdata <= file_wdata;
			null_rd_q <= access_en && file_rd && null_target;
		end
	end

endmodule : pcsiu_indirect

// file: logic/pcsiu_pkg.sv
package pcsiu_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PC_W = 9;
	localparam int STK_W = 12;
	localparam int STK_DEPTH = 4;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int PTR_W = 5;
	localparam int LOW_W = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0] PC_RESET = 9'h1FF;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
	localparam logic [DATA_W-1:0] NULL_DATA = 8'h00;

	// ----------------------------------------------------------------
	// data memory addresses and field positions
	// ----------------------------------------------------------------
	localparam logic [FADDR_W-1:0] ADDR_INDIRECT = 5'h00;
	localparam logic [FADDR_W-1:0] ADDR_PC_LOW = 5'h02;
	localparam logic [FADDR_W-1:0] ADDR_STATUS = 5'h03;
	localparam logic [FADDR_W-1:0] ADDR_POINTER = 5'h04;
	localparam int PAGE_LO_BIT = 5;
	localparam int PAGE_HI_BIT = 6;
	localparam int PC_HI_BIT = 8;
	// pointer read view: bits 6:5 read as ones, bit 7 as zero
	localparam logic [2:0] PTR_UPPER_VIEW = 3'h3;
	localparam logic [PC_W-1:0] PC_ONE = 9'h001;

	// ----------------------------------------------------------------
	// operations presented by the decoder
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PCSIU_OP_SEQ,
		PCSIU_OP_GOTO,
		PCSIU_OP_CALL,
		PCSIU_OP_RETURN_WITH_LITERAL
	} pcsiu_op_t;

	typedef struct packed {
		pcsiu_op_t op;
		logic [PC_W-1:0] target;
		logic [DATA_W-1:0] literal;
		logic [FADDR_W-1:0] file_addr;
		logic file_rd;
		logic file_wr;
		logic [DATA_W-1:0] file_wdata;
	} pcsiu_instr_t;

	typedef struct packed {
		logic [FADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic [DATA_W-1:0] wdata;
	} pcsiu_mem_t;

endpackage : pcsiu_pkg

// file: logic/pcsiu_stack.sv
`timescale 1ns/1ps
module pcsiu_stack (
	// clock
	input wire logic ref_clk,
	// stack operations
	input wire logic push,
	input wire logic pop,
	input wire logic [pcsiu_pkg::STK_W-1:0] push_data,
	// level 1 view
	output logic [pcsiu_pkg::STK_W-1:0] top_q
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// no reset: levels keep their contents across any reset
	logic [pcsiu_pkg::STK_W-1:0] level_q [pcsiu_pkg::STK_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			for (int i = pcsiu_pkg::STK_DEPTH - 1; i > 0; i--) begin
				level_q[i] <= level_q[i-1];
			end
			level_q[0] <= push_data;
		end else if (pop) begin
			for (int i = 0; i < pcsiu_pkg::STK_DEPTH - 1; i++) begin
				level_q[i] <= level_q[i+1];
			end
			// bottom level left alone so it repeats on underflow
			level_q[pcsiu_pkg::STK_DEPTH-1] <= level_q[pcsiu_pkg::STK_DEPTH-1];
		end
	end

	assign top_q = level_q[0];

endmodule : pcsiu_stack

// file: logic/pcsiu_top.sv
`timescale 1ns/1ps
module pcsiu_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// executing instruction from the decoder
	input wire logic instr_valid,
	input wire pcsiu_pkg::pcsiu_instr_t instr,
	// read data returned by the register file
	input wire logic [pcsiu_pkg::DATA_W-1:0] mem_rdata,
	// fetch side
	output logic [pcsiu_pkg::PC_W-1:0] program_counter_q,
	output logic [pcsiu_pkg::PC_W-1:0] exec_pc_q,
	output logic discard_q,
	// status page select
	output logic page_select_bit_lo_q,
	output logic page_select_bit_hi_q,
	// working register load
	output logic w_load_q,
	output logic [pcsiu_pkg::DATA_W-1:0] w_data_q,
	// register file access
	output pcsiu_pkg::pcsiu_mem_t mem_q,
	output logic rd_valid_q,
	output logic [pcsiu_pkg::DATA_W-1:0] rd_data_q
);

	// ----------------------------------------------------------------
	// sequencing state
	// ----------------------------------------------------------------
	typedef enum logic {
		PCSIU_ST_EXEC,
		PCSIU_ST_DISCARD
	} pcsiu_state_t;

	pcsiu_state_t state_q;
	pcsiu_state_t state_d;

	logic exec_en;
	logic do_goto;
	logic do_call;
	logic do_ret;
	logic pcl_write;
	logic status_write;
	logic branch;
	logic [pcsiu_pkg::PC_W-1:0] pc_d;
	logic [pcsiu_pkg::PC_W-1:0] exec_pc_d;
	logic [pcsiu_pkg::PC_W-1:0] pc_inc;
	logic [pcsiu_pkg::STK_W-1:0] stack_top;
	logic [pcsiu_pkg::STK_W-1:0] push_value;

	// resolved file access
	logic [pcsiu_pkg::FADDR_W-1:0] eff_addr;
	logic eff_wr;
	logic null_rd_q;
	logic [pcsiu_pkg::DATA_W-1:0] ptr_view_q;

	// the instruction in the slot behind a branch was fetched from the old
	// path; it is not executed, so neither its stack nor file effects occur
	assign exec_en = instr_valid && (state_q == PCSIU_ST_EXEC);

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	always_comb begin
		do_goto = exec_en && (instr.op == pcsiu_pkg::PCSIU_OP_GOTO);
		do_call = exec_en && (instr.op == pcsiu_pkg::PCSIU_OP_CALL);
		do_ret = exec_en && (instr.op == pcsiu_pkg::PCSIU_OP_RETURN_WITH_LITERAL);
		// push and pop happen here only, never through a file access
		pcl_write = eff_wr && (eff_addr == pcsiu_pkg::ADDR_PC_LOW);
		status_write = eff_wr && (eff_addr == pcsiu_pkg::ADDR_STATUS);
		branch = do_goto || do_call || do_ret || pcl_write;
	end

	assign pc_inc = program_counter_q + pcsiu_pkg::PC_ONE;

	// ----------------------------------------------------------------
	// next program counter
	// ----------------------------------------------------------------
	always_comb begin
		pc_d = pc_inc;
		if (do_goto) begin
			pc_d = instr.target;
		end else if (do_call) begin
			pc_d = {1'b0, instr.target[pcsiu_pkg::LOW_W-1:0]};
		end else if (pcl_write) begin
			pc_d = {1'b0, instr.file_wdata};
		end else if (do_ret) begin
			pc_d = stack_top[pcsiu_pkg::PC_W-1:0];
		end
	end

	// the counter is the fetch address; the instruction now executing
	// was fetched from the previous value of it
	always_comb begin
		exec_pc_d = program_counter_q;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			program_counter_q <= pcsiu_pkg::PC_RESET;
		end else begin
			program_counter_q <= pc_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			exec_pc_q <= pcsiu_pkg::PC_RESET;
		end else begin
			exec_pc_q <= exec_pc_d;
		end
	end

	// ----------------------------------------------------------------
	// branch discard slot
	// ----------------------------------------------------------------
	always_comb begin
		case (state_q)
			PCSIU_ST_EXEC: begin
				state_d = branch ? PCSIU_ST_DISCARD : PCSIU_ST_EXEC;
			end
			PCSIU_ST_DISCARD: begin
				state_d = PCSIU_ST_EXEC;
			end
			default: begin
				state_d = PCSIU_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= PCSIU_ST_EXEC;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			discard_q <= 1'b0;
		end else begin
			discard_q <= (state_d == PCSIU_ST_DISCARD);
		end
	end

	// ----------------------------------------------------------------
	// page select bits
	// ----------------------------------------------------------------
	// only the two page bits of the status register live here; the other
	// bits are kept by the register file, which also sees the write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			page_select_bit_lo_q <= pcsiu_pkg::PAGE_RESET[0];
			page_select_bit_hi_q <= pcsiu_pkg::PAGE_RESET[1];
		end else if (status_write) begin
			page_select_bit_lo_q <= instr.file_wdata[pcsiu_pkg::PAGE_LO_BIT];
			page_select_bit_hi_q <= instr.file_wdata[pcsiu_pkg::PAGE_HI_BIT];
		end
	end

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	// pushed value is the address after the call, already in the counter;
	// upper bits beyond the counter width are stored as zero
	assign push_value = {{(pcsiu_pkg::STK_W - pcsiu_pkg::PC_W){1'b0}}, program_counter_q};

	pcsiu_stack u_stack (
		.ref_clk (ref_clk),
		.push (do_call),
		.pop (do_ret),
		.push_data (push_value),
		.top_q (stack_top)
	);

	// stack storage carries no reset at all, so a reset leaves it intact

	// ----------------------------------------------------------------
	// working register load from the literal
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			w_load_q <= 1'b0;
			w_data_q <= pcsiu_pkg::NULL_DATA;
		end else begin
			w_load_q <= do_ret;
			if (do_ret) begin
				w_data_q <= instr.literal;
			end
		end
	end

	// ----------------------------------------------------------------
	// indirect data access
	// ----------------------------------------------------------------
	pcsiu_indirect u_indirect (
		.ref_clk (ref_clk),
		.rstn (rstn),
		.access_en (exec_en),
		.file_addr (instr.file_addr),
		.file_rd (instr.file_rd),
		.file_wr (instr.file_wr),
		.file_wdata (instr.file_wdata),
		.eff_addr (eff_addr),
		.eff_wr (eff_wr),
		.mem_q (mem_q),
		.null_rd_q (null_rd_q),
		.ptr_view_q (ptr_view_q)
	);

	// read data lands one cycle after the registered request, giving the
	// register file a full cycle to answer; a read of the pointer register
	// is answered here from the pointer and its fixed upper bits, not from the register file's copy
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= pcsiu_pkg::NULL_DATA;
		end else begin
			rd_valid_q <= mem_q.rd || null_rd_q;
			if (null_rd_q) begin
				rd_data_q <= pcsiu_pkg::NULL_DATA;
			end else if (mem_q.rd && mem_q.addr == pcsiu_pkg::ADDR_POINTER) begin
				rd_data_q <= ptr_view_q;
			end else if (mem_q.rd) begin
				rd_data_q <= mem_rdata;
			end
		end
	end

endmodule : pcsiu_top
